//--- design/dhsc_regs.svh
// Constants for the differential hot-swap connect block
`ifndef DHSC_REGS_SVH
`define DHSC_REGS_SVH

`define DHSC_CLK_HZ 40000000
`define DHSC_CYC_PER_US (`DHSC_CLK_HZ / 1000000)
`define DHSC_T_REF_US 1000
`define DHSC_T_TERM_US 10000
`define DHSC_T_IDLE_US 100
`define DHSC_TMR_W 20

`define DHSC_IN_W 13
`define DHSC_B_SCL 0
`define DHSC_B_SDA 1
`define DHSC_B_CP 2
`define DHSC_B_CM 3
`define DHSC_B_DP 4
`define DHSC_B_DM 5
`define DHSC_B_TERM_LO 6
`define DHSC_B_TERM_HI 9
`define DHSC_B_EN 10
`define DHSC_B_SUP 11
`define DHSC_B_REF 12

`define DHSC_IN_RST 13'h0000
`define DHSC_RX_RST 1'h1

`endif

//--- design/dhsc_pkg.sv
// Types for the differential hot-swap connect block
package dhsc_pkg;

	typedef enum logic [2:0] {
		SEQ_OFF = 3'b000,
		SEQ_REF = 3'b001,
		SEQ_TERM = 3'b010,
		SEQ_SETTLE = 3'b011,
		SEQ_ARMED = 3'b100,
		SEQ_JOINED = 3'b101
	} dhsc_seq_t;

	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_TO_DIFF = 2'b01,
		CH_TO_CARD = 2'b10,
		CH_GUARD = 2'b11
	} dhsc_dir_t;

endpackage

//--- design/dhsc_chan.sv
// One channel: picks the flow direction from bus activity
`timescale 1ns/1ps
`default_nettype none

module dhsc_chan (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic joined,
	input wire logic card_low,
	input wire logic diff_low,
	output logic drv_card,
	output logic drv_diff
);
	import dhsc_pkg::*;

	typedef struct packed {
		dhsc_dir_t dir;
		logic drv_card_q;
		logic drv_diff_q;
	} dhsc_chan_st_t;

	dhsc_chan_st_t s;
	dhsc_chan_st_t n;

	always_comb begin
		n = s;
		if (!joined) begin
			n.dir = CH_IDLE;
		end else begin
			unique case (s.dir)
				CH_IDLE: begin
					if (diff_low) begin
						n.dir = CH_TO_CARD; // RULE16
					end else if (card_low) begin
						n.dir = CH_TO_DIFF; // RULE1
					end
				end
				CH_TO_CARD: begin
					if (!diff_low) begin
						n.dir = CH_GUARD;
					end
				end
				CH_TO_DIFF: begin
					if (!card_low) begin
						n.dir = CH_GUARD;
					end
				end
				// Let our own released level settle before listening again
				CH_GUARD: begin
					if (!card_low && !diff_low) begin
						n.dir = CH_IDLE; // RULE2
					end
				end
			endcase
		end
		n.drv_card_q = (n.dir == CH_TO_CARD);
		n.drv_diff_q = (n.dir == CH_TO_DIFF); // RULE2
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '{dir: CH_IDLE, drv_card_q: 1'h0, drv_diff_q: 1'h0};
		end else begin
			s <= n;
		end
	end

	assign drv_card = s.drv_card_q;
	assign drv_diff = s.drv_diff_q;

	a_dir_exclusive: assert property (@(posedge mclk) disable iff (!rst_b) // RULE2
		!(drv_card && drv_diff))
		else $error("channel drives both sides");

	a_split_drops: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
		!joined |=> !drv_card && !drv_diff)
		else $error("channel still drives after split");

	a_rx_pulls_card: assert property (@(posedge mclk) disable iff (!rst_b) // RULE16
		joined && s.dir == CH_IDLE && diff_low |=> drv_card)
		else $error("differential low not passed to card side");

endmodule // dhsc_chan
`default_nettype wire

//--- design/dhsc_top.sv
// Hot-swap connect control between a card-side bus and a differential bus
// Notes on behaviour
// RULE1 - Flow direction chosen from bus activity only
// RULE2 - Each channel transmits or receives, never both
// RULE3 - Plus above minus is HIGH, reversed LOW
// RULE4 - Enable LOW forbids and breaks the join
// RULE5 - Join needs enable, power, STOP or idle
// RULE6 - Outside party toggles enable only when idle
// RULE7 - All outputs released while powering up
// RULE8 - References stable start 1 ms timer
// RULE9 - Valid termination starts the second timer
// RULE10 - After 10 ms arm detection, stay unjoined
// RULE11 - Join only after full enable sequence
// RULE12 - Join on idle time or STOP
// RULE13 - Loss of link or power reruns sequence
// RULE14 - Common mode ignored, only difference matters
// RULE15 - Enable is active HIGH, default on
// RULE16 - Received differential LOW pulls card line
// RULE17 - STOP is data rising while clock HIGH
// RULE18 - Bus idle time is a parameter
`timescale 1ns/1ps
`default_nettype none
`include "dhsc_regs.svh"

module dhsc_top #(
	parameter int unsigned P_REF_CYC = `DHSC_T_REF_US * `DHSC_CYC_PER_US,
	parameter int unsigned P_TERM_CYC = `DHSC_T_TERM_US * `DHSC_CYC_PER_US,
	parameter int unsigned P_IDLE_CYC = `DHSC_T_IDLE_US * `DHSC_CYC_PER_US
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ref_ok,
	input wire logic supply_ok,
	input wire logic en,
	input wire logic card_scl_in,
	input wire logic card_sda_in,
	input wire logic diff_clock_plus_in,
	input wire logic diff_clock_minus_in,
	input wire logic diff_data_plus_in,
	input wire logic diff_data_minus_in,
	input wire logic [1:0] minus_below_lim,
	input wire logic [1:0] plus_above_lim,
	output logic card_scl_out,
	output logic card_scl_oe,
	output logic card_sda_out,
	output logic card_sda_oe,
	output logic diff_clock_plus_out,
	output logic diff_clock_plus_oe,
	output logic diff_clock_minus_out,
	output logic diff_clock_minus_oe,
	output logic diff_data_plus_out,
	output logic diff_data_plus_oe,
	output logic diff_data_minus_out,
	output logic diff_data_minus_oe,
	output logic joined,
	output logic hot_swap_ready
);
	import dhsc_pkg::*;

	localparam int TW = `DHSC_TMR_W;
	localparam int IW = `DHSC_IN_W;
	localparam logic [TW-1:0] REF_END = TW'(P_REF_CYC - 1);
	localparam logic [TW-1:0] TERM_END = TW'(P_TERM_CYC - 1);
	localparam logic [TW-1:0] IDLE_END = TW'(P_IDLE_CYC - 1);

	typedef struct packed {
		logic [IW-1:0] s1;
		logic [IW-1:0] s2;
		logic [IW-1:0] s3;
		logic [IW-1:0] f;
		logic ck_st;
		logic da_st;
		logic da_prev;
		dhsc_seq_t seq;
		logic [TW-1:0] tmr;
		logic [TW-1:0] idle;
		logic stop_seen;
		logic scl_oe;
		logic sda_oe;
		logic cp_oe;
		logic cm_oe;
		logic dp_oe;
		logic dm_oe;
		logic lo_q;
		logic hi_q;
		logic joined_q;
		logic ready_q;
	} dhsc_top_st_t;

	dhsc_top_st_t s;
	dhsc_top_st_t n;

	logic [IW-1:0] raw;
	logic [1:0] drv_card;
	logic [1:0] drv_diff;
	logic [1:0] card_low;
	logic [1:0] diff_low;
	logic pwr_ok;
	logic term_ok;
	logic bus_idle;
	logic idle_done;
	logic card_hi;
	logic stop_ev;
	logic start_ev;
	logic lost;
	logic jn;

	assign raw = {ref_ok, supply_ok, en, plus_above_lim, minus_below_lim,
		diff_data_minus_in, diff_data_plus_in, diff_clock_minus_in,
		diff_clock_plus_in, card_sda_in, card_scl_in};

	assign pwr_ok = s.f[`DHSC_B_REF] && s.f[`DHSC_B_SUP];
	assign term_ok = &s.f[`DHSC_B_TERM_HI:`DHSC_B_TERM_LO]; // RULE9
	assign bus_idle = s.ck_st && s.da_st;
	assign idle_done = (s.idle == IDLE_END);
	assign card_hi = s.f[`DHSC_B_SCL] && s.f[`DHSC_B_SDA];
	assign stop_ev = s.ck_st && !s.da_prev && s.da_st; // RULE17
	assign start_ev = s.ck_st && s.da_prev && !s.da_st;
	assign lost = !term_ok && bus_idle;

	assign card_low = ~{s.f[`DHSC_B_SDA], s.f[`DHSC_B_SCL]};
	assign diff_low = ~{s.da_st, s.ck_st};

	// Direction logic per channel, clock then data
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_chan
			dhsc_chan u_chan (
				.mclk(mclk),
				.rst_b(rst_b),
				.joined(s.seq == SEQ_JOINED),
				.card_low(card_low[gi]),
				.diff_low(diff_low[gi]),
				.drv_card(drv_card[gi]),
				.drv_diff(drv_diff[gi])
			);
		end
	endgenerate

	always_comb begin
		n = s;
		// Pin inputs: a change counts once stages two and three agree
		n.s1 = raw;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.f = (s.s2 & s.s3) | (s.f & (s.s2 ^ s.s3));

		// Receivers: sign of the difference only
		if (s.f[`DHSC_B_CP] && !s.f[`DHSC_B_CM]) begin
			n.ck_st = 1'h1; // RULE3
		end else if (!s.f[`DHSC_B_CP] && s.f[`DHSC_B_CM]) begin
			n.ck_st = 1'h0; // RULE3
		end
		if (s.f[`DHSC_B_DP] && !s.f[`DHSC_B_DM]) begin
			n.da_st = 1'h1; // RULE14
		end else if (!s.f[`DHSC_B_DP] && s.f[`DHSC_B_DM]) begin
			n.da_st = 1'h0; // RULE14
		end
		n.da_prev = s.da_st;

		unique case (s.seq)
			SEQ_OFF: begin
				if (pwr_ok) begin
					n.seq = SEQ_REF; // RULE8
					n.tmr = '0;
				end
			end
			SEQ_REF: begin
				if (s.tmr == REF_END) begin
					n.seq = SEQ_TERM; // RULE8
				end else begin
					n.tmr = s.tmr + 1'h1;
				end
			end
			SEQ_TERM: begin
				if (term_ok) begin
					n.seq = SEQ_SETTLE; // RULE9
					n.tmr = '0;
				end
			end
			SEQ_SETTLE: begin
				if (!term_ok) begin
					n.seq = SEQ_TERM;
				end else if (s.tmr == TERM_END) begin
					n.seq = SEQ_ARMED; // RULE10
				end else begin
					n.tmr = s.tmr + 1'h1;
				end
			end
			SEQ_ARMED: begin
				// Enable HIGH means connect; a floating pin reads HIGH
				if (s.f[`DHSC_B_EN] && (idle_done || (s.stop_seen && card_hi))) begin
					n.seq = SEQ_JOINED; // RULE5 RULE11 RULE12 RULE15
				end
			end
			SEQ_JOINED: begin
				// Enable is expected to move only while the bus is idle
				if (!s.f[`DHSC_B_EN]) begin
					n.seq = SEQ_ARMED; // RULE4 RULE6
				end
			end
			default: begin
				n.seq = SEQ_OFF;
			end
		endcase
		if (!pwr_ok || (lost && (s.seq == SEQ_ARMED || s.seq == SEQ_JOINED))) begin
			n.seq = SEQ_OFF; // RULE13
		end

		// Stop and idle detection run only while armed
		if (s.seq == SEQ_ARMED) begin
			if (!bus_idle) begin
				n.idle = '0;
			end else if (!idle_done) begin
				n.idle = s.idle + 1'h1; // RULE18
			end
			if (stop_ev) begin
				n.stop_seen = 1'h1; // RULE17
			end else if (start_ev) begin
				n.stop_seen = 1'h0;
			end
		end else begin
			n.idle = '0;
			n.stop_seen = 1'h0;
		end

		jn = (n.seq == SEQ_JOINED);
		n.joined_q = jn;
		n.ready_q = (n.seq == SEQ_ARMED) || jn;
		n.scl_oe = jn && drv_card[0]; // RULE7
		n.sda_oe = jn && drv_card[1];
		n.cp_oe = jn && drv_diff[0]; // RULE2
		n.cm_oe = jn && drv_diff[0];
		n.dp_oe = jn && drv_diff[1];
		n.dm_oe = jn && drv_diff[1];
		n.lo_q = 1'h0;
		n.hi_q = 1'h1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.s1 <= `DHSC_IN_RST;
			s.s2 <= `DHSC_IN_RST;
			s.s3 <= `DHSC_IN_RST;
			s.f <= `DHSC_IN_RST;
			s.ck_st <= `DHSC_RX_RST;
			s.da_st <= `DHSC_RX_RST;
			s.da_prev <= `DHSC_RX_RST;
			s.seq <= SEQ_OFF;
		end else begin
			s <= n;
		end
	end

	// Driving LOW: plus pulled down, minus pulled up
	assign card_scl_out = s.lo_q;
	assign card_sda_out = s.lo_q;
	assign card_scl_oe = s.scl_oe;
	assign card_sda_oe = s.sda_oe;
	assign diff_clock_plus_out = s.lo_q;
	assign diff_clock_minus_out = s.hi_q;
	assign diff_data_plus_out = s.lo_q;
	assign diff_data_minus_out = s.hi_q;
	assign diff_clock_plus_oe = s.cp_oe;
	assign diff_clock_minus_oe = s.cm_oe;
	assign diff_data_plus_oe = s.dp_oe;
	assign diff_data_minus_oe = s.dm_oe;
	assign joined = s.joined_q;
	assign hot_swap_ready = s.ready_q;

	a_no_join_off: assert property (@(posedge mclk) disable iff (!rst_b) // RULE4
		!s.f[`DHSC_B_EN] |=> !joined)
		else $error("joined while enable low");

	a_pins_released: assert property (@(posedge mclk) disable iff (!rst_b) // RULE7
		!joined |-> !(card_scl_oe || card_sda_oe || diff_clock_plus_oe ||
			diff_clock_minus_oe || diff_data_plus_oe || diff_data_minus_oe))
		else $error("pin driven while not joined");

	a_ref_timer: assert property (@(posedge mclk) disable iff (!rst_b) // RULE8
		$past(s.seq) == SEQ_REF && s.seq == SEQ_TERM |-> $past(s.tmr) == REF_END)
		else $error("reference timer ended early");

	a_settle_timer: assert property (@(posedge mclk) disable iff (!rst_b) // RULE10
		$past(s.seq) == SEQ_SETTLE && s.seq == SEQ_ARMED |-> $past(s.tmr) == TERM_END)
		else $error("termination timer ended early");

	a_join_from_arm: assert property (@(posedge mclk) disable iff (!rst_b) // RULE11
		$rose(joined) |-> $past(s.seq) == SEQ_ARMED && $past(s.f[`DHSC_B_EN]))
		else $error("join without armed sequence");

	a_join_cause: assert property (@(posedge mclk) disable iff (!rst_b) // RULE12
		$rose(joined) && !$past(idle_done) |-> $past(s.stop_seen) && $past(card_hi))
		else $error("join without stop or idle");

	a_rx_decode: assert property (@(posedge mclk) disable iff (!rst_b) // RULE3
		s.f[`DHSC_B_DP] && !s.f[`DHSC_B_DM] |=> s.da_st)
		else $error("data pair decode wrong");

	a_link_lost: assert property (@(posedge mclk) disable iff (!rst_b) // RULE13
		s.seq == SEQ_JOINED && lost |=> s.seq == SEQ_OFF ##1 !joined)
		else $error("link loss did not restart sequence");

endmodule // dhsc_top
`default_nettype wire

//--- tb/dhsc_far.sv
// Far-side model: remote differential node, cable bias and termination sensing
`timescale 1ns/1ps
`default_nettype none

module dhsc_far (
	input wire logic cp_oe,
	input wire logic cm_oe,
	input wire logic dp_oe,
	input wire logic dm_oe,
	input wire logic rem_cl,
	input wire logic rem_dl,
	input wire logic cm_fault,
	input wire logic term_ok,
	output logic cp,
	output logic cm,
	output logic dp,
	output logic dm,
	output logic [1:0] mbl,
	output logic [1:0] pal
);
	logic cl_low;
	logic dl_low;
	assign cl_low = cp_oe | cm_oe | rem_cl;
	assign dl_low = dp_oe | dm_oe | rem_dl;
	// Bias keeps plus above minus when released; no bias without termination
	assign cp = term_ok & !cl_low;
	assign cm = cl_low;
	assign dp = (term_ok & !dl_low) | cm_fault;
	assign dm = dl_low | cm_fault;
	assign mbl = {2{term_ok}};
	assign pal = {2{term_ok}};
endmodule // dhsc_far

`default_nettype wire

//--- tb/dhsc_top_tb.sv
// Testbench for the hot-swap connect block
`timescale 1ns/1ps
`default_nettype none

module dhsc_top_tb;
	logic mclk, rst_b, ref_ok, supply_ok, en, term_ok, cm_fault;
	logic pull_scl, pull_sda, rem_cl, rem_dl;
	logic scl_in, sda_in, cp, cm, dp, dm;
	logic [1:0] mbl, pal;
	logic scl_oe, sda_oe, cp_oe, cm_oe, dp_oe, dm_oe, joined, rdy;
	logic scl_o, sda_o, cpo, cmo, dpo, dmo;
	int mismatches;
	int samples_checked;

	// Card lines: open drain with pull-ups
	assign scl_in = !(scl_oe | pull_scl);
	assign sda_in = !(sda_oe | pull_sda);

	dhsc_top #(.P_REF_CYC(20), .P_TERM_CYC(40), .P_IDLE_CYC(200)) dut_u (
		.mclk(mclk), .rst_b(rst_b), .ref_ok(ref_ok), .supply_ok(supply_ok), .en(en),
		.card_scl_in(scl_in), .card_sda_in(sda_in),
		.diff_clock_plus_in(cp), .diff_clock_minus_in(cm),
		.diff_data_plus_in(dp), .diff_data_minus_in(dm),
		.minus_below_lim(mbl), .plus_above_lim(pal),
		.card_scl_out(scl_o), .card_scl_oe(scl_oe), .card_sda_out(sda_o), .card_sda_oe(sda_oe),
		.diff_clock_plus_out(cpo), .diff_clock_plus_oe(cp_oe),
		.diff_clock_minus_out(cmo), .diff_clock_minus_oe(cm_oe),
		.diff_data_plus_out(dpo), .diff_data_plus_oe(dp_oe),
		.diff_data_minus_out(dmo), .diff_data_minus_oe(dm_oe),
		.joined(joined), .hot_swap_ready(rdy)
	);

	dhsc_far far_u (
		.cp_oe(cp_oe), .cm_oe(cm_oe), .dp_oe(dp_oe), .dm_oe(dm_oe),
		.rem_cl(rem_cl), .rem_dl(rem_dl), .cm_fault(cm_fault), .term_ok(term_ok),
		.cp(cp), .cm(cm), .dp(dp), .dm(dm), .mbl(mbl), .pal(pal)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic chk(input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t mismatch seen %b expected %b", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Bounded wait on ready or joined
	task automatic wt(input bit r, input logic v, input int n);
		for (int i = 0; i < n && (r ? rdy : joined) !== v; i++) cyc(1);
	endtask

	task automatic t_powerup;
		cyc(30);
		chk(rdy, 1'b0);
		chk(sda_oe | scl_oe | cp_oe | cm_oe | dp_oe | dm_oe, 1'b0);
		term_ok = 1'b1;
		cyc(35);
		chk(rdy, 1'b0);
		wt(1, 1'b1, 30);
		chk(rdy, 1'b1);
		chk(joined, 1'b0);
	endtask

	task automatic t_en_low;
		cyc(250);
		chk(joined, 1'b0);
		// Brief clock pair activity restarts the idle count
		rem_cl = 1'b1;
		cyc(10);
		rem_cl = 1'b0;
		cyc(8);
		en = 1'b1;
		cyc(150);
		chk(joined, 1'b0);
		wt(0, 1'b1, 80);
		chk(joined, 1'b1);
	endtask

	task automatic t_pass;
		rem_dl = 1'b1;
		cyc(10);
		chk(sda_oe, 1'b1);
		chk(sda_o, 1'b0);
		chk(dp_oe | dm_oe, 1'b0);
		rem_dl = 1'b0;
		cyc(16);
		chk(sda_oe, 1'b0);
		pull_sda = 1'b1;
		cyc(10);
		chk(dp_oe & dm_oe, 1'b1);
		chk(dpo, 1'b0);
		chk(dmo, 1'b1);
		chk(sda_oe, 1'b0);
		pull_sda = 1'b0;
		cyc(16);
		chk(dp_oe, 1'b0);
		rem_cl = 1'b1;
		cyc(10);
		chk(scl_oe, 1'b1);
		chk(scl_o, 1'b0);
		rem_cl = 1'b0;
		cyc(16);
		pull_scl = 1'b1;
		cyc(10);
		chk(cp_oe & cm_oe, 1'b1);
		chk(cpo, 1'b0);
		chk(cmo, 1'b1);
		chk(scl_oe, 1'b0);
		pull_scl = 1'b0;
		cyc(16);
		chk(cp_oe | cm_oe, 1'b0);
		cm_fault = 1'b1;
		cyc(10);
		chk(sda_oe, 1'b0);
		cm_fault = 1'b0;
		cyc(8);
	endtask

	task automatic t_stop;
		en = 1'b0;
		wt(0, 1'b0, 8);
		chk(joined, 1'b0);
		cyc(5);
		en = 1'b1;
		cyc(2);
		rem_dl = 1'b1;
		cyc(4);
		repeat (2) begin
			rem_cl = 1'b1;
			cyc(4);
			rem_cl = 1'b0;
			cyc(4);
		end
		chk(joined, 1'b0);
		rem_dl = 1'b0;
		cyc(10);
		chk(joined, 1'b1);
	endtask

	task automatic t_loss;
		supply_ok = 1'b0;
		cyc(8);
		chk(joined | rdy, 1'b0);
		chk(sda_oe | scl_oe | cp_oe | dp_oe, 1'b0);
		supply_ok = 1'b1;
		cyc(55);
		chk(rdy, 1'b0);
		wt(1, 1'b1, 40);
		chk(rdy, 1'b1);
		chk(joined, 1'b0);
		wt(0, 1'b1, 240);
		chk(joined, 1'b1);
		term_ok = 1'b0;
		cyc(8);
		chk(rdy | joined, 1'b0);
	endtask

	task automatic wrap_up;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		ref_ok = 1'b1;
		supply_ok = 1'b1;
		en = 1'b0;
		term_ok = 1'b0;
		cm_fault = 1'b0;
		pull_scl = 1'b0;
		pull_sda = 1'b0;
		rem_cl = 1'b0;
		rem_dl = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		cyc(2);
		rst_b = 1'b1;
		t_powerup;
		t_en_low;
		t_pass;
		t_stop;
		t_loss;
		wrap_up;
	end

	initial begin
		#200000;
		mismatches++;
		wrap_up;
	end
endmodule // dhsc_top_tb

`default_nettype wire
